// file: src/msi_cap_pkg.sv
/*
 Constants, register layout and carrier types for the message signalled
 interrupt capability block of one switch port.
 Assumes a single 25 MHz configuration clock and an APB register master.
*/
// Operation
// - Capability identifier byte always reads as constant 0x5.
// - Next capability pointer resets to zero, ending the list.
// - Writable enable bit gates messages; resets to 0.
// - Requested message count is read-only zero.
// - Allocated message count acts as one message; resets to zero.
// - Wide address capable bit reads as 1.
// - Lower address holds bits 31:2; bits 1:0 read zero.
// - Non-zero upper address gives 64-bit write, else 32-bit only.
// - Generated messages always route upstream, whatever the address.
// - Message data is low 16 bits; upper half reads zero.
package msi_cap_pkg;
   localparam logic [11:0] CAP_CTRL_OFS = 12'h0d0;
   localparam logic [11:0] ADDR_LOW_OFS = 12'h0d4;
   localparam logic [11:0] ADDR_HIGH_OFS = 12'h0d8;
   localparam logic [11:0] PAYLOAD_OFS = 12'h0dc;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h0e0;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h0e4;

   localparam logic [7:0] CAP_ID_VALUE = 8'h05;
   localparam logic [7:0] NEXT_PTR_RESET = 8'h00;
   localparam int NEXT_PTR_LSB = 8;
   localparam int ENABLE_BIT = 16;
   localparam int REQ_COUNT_LSB = 17;
   localparam int ALLOC_COUNT_LSB = 20;
   localparam int WIDE_BIT = 23;
   localparam logic [2:0] REQ_COUNT_VALUE = 3'h0;
   localparam logic [2:0] ALLOC_COUNT_RESET = 3'h0;
   localparam logic WIDE_VALUE = 1'b1;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [15:0] PAYLOAD_RESET = 16'h0000;

   localparam int IRQ_SENT_BIT = 0;
   localparam int IRQ_DROP_BIT = 1;
   localparam int IRQ_WIDTH = 2;

   typedef enum {ST_IDLE, ST_ISSUE} send_state_e;

   typedef struct packed {
      logic [63:0] address;
      logic [31:0] data;
      logic wide;
      logic to_upstream;
   } msg_write_s;

   typedef struct packed {
      logic enable;
      logic [7:0] next_ptr;
      logic [2:0] alloc_count;
      logic [29:0] addr_low;
      logic [31:0] addr_high;
      logic [15:0] payload;
   } msi_regs_s;
endpackage

// file: src/msi_irq_status.sv
/*
 Sticky event status with mask and one level interrupt output.
 Assumes events are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module msi_irq_status
   import msi_cap_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [IRQ_WIDTH-1:0] event_in,
   input wire logic status_clr_we,
   input wire logic mask_we,
   input wire logic [IRQ_WIDTH-1:0] wdata,
   output logic [IRQ_WIDTH-1:0] status,
   output logic [IRQ_WIDTH-1:0] mask,
   output logic irq
);
   typedef struct packed {
      logic [IRQ_WIDTH-1:0] status;
      logic [IRQ_WIDTH-1:0] mask;
      logic irq;
   } irq_state_s;

   irq_state_s state_reg;
   irq_state_s state_next;

   always_comb begin
      state_next = state_reg;
      // Set wins over a clear in the same cycle
      if (status_clr_we) begin
         state_next.status = state_reg.status & ~wdata;
      end
      state_next.status = state_next.status | event_in;
      if (mask_we) begin
         state_next.mask = wdata;
      end
      state_next.irq = |(state_next.status & state_next.mask);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign status = state_reg.status;
   assign mask = state_reg.mask;
   assign irq = state_reg.irq;
endmodule // msi_irq_status

// file: src/msi_capability_block.sv
/*
 Message signalled interrupt capability registers on APB, plus the
 memory write that signals an interrupt.
 Assumes the port's event source pulses MSG_REQUEST on REF_CLK and the
 upstream path accepts the write with MSG_READY.
*/
`timescale 1ns/1ps
module msi_capability_block
   import msi_cap_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic MSG_REQUEST,
   output logic MSG_VALID,
   input wire logic MSG_READY,
   output msg_write_s MSG_WRITE,
   output logic IRQ
);
   typedef struct packed {
      msi_regs_s regs;
      send_state_e state;
      msg_write_s msg;
      logic [31:0] rdata;
      logic sent_evt;
      logic drop_evt;
      // Read data lags one cycle, so every access takes one wait state
      logic waited;
   } block_state_s;

   block_state_s s_reg;
   block_state_s s_next;
   logic [IRQ_WIDTH-1:0] irq_status;
   logic [IRQ_WIDTH-1:0] irq_mask;
   logic access;
   logic wr;
   logic mapped;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] ctrl_word(input msi_regs_s r);
      logic [31:0] w;
      w = '0;
      w[7:0] = CAP_ID_VALUE;
      w[NEXT_PTR_LSB +: 8] = r.next_ptr;
      w[ENABLE_BIT] = r.enable;
      w[REQ_COUNT_LSB +: 3] = REQ_COUNT_VALUE;
      w[ALLOC_COUNT_LSB +: 3] = r.alloc_count;
      w[WIDE_BIT] = WIDE_VALUE;
      return w;
   endfunction

   assign access = PSEL & PENABLE;
   // Writes land only at the edge where the master sees PREADY
   assign wr = access & PWRITE & s_reg.waited;
   assign mapped = (PADDR == CAP_CTRL_OFS) || (PADDR == ADDR_LOW_OFS) || (PADDR == ADDR_HIGH_OFS)
      || (PADDR == PAYLOAD_OFS) || (PADDR == IRQ_STATUS_OFS) || (PADDR == IRQ_MASK_OFS);

   always_comb begin
      logic [31:0] cw;
      logic [31:0] nw;
      cw = ctrl_word(s_reg.regs);
      nw = '0;
      s_next = s_reg;
      s_next.sent_evt = 1'b0;
      s_next.drop_evt = 1'b0;
      s_next.waited = access & ~s_reg.waited;

      // Register writes
      if (wr) begin
         case (PADDR)
            CAP_CTRL_OFS: begin
               nw = merge(cw, PWDATA, PSTRB);
               s_next.regs.next_ptr = nw[NEXT_PTR_LSB +: 8];
               s_next.regs.enable = nw[ENABLE_BIT];
               // Only one message is ever allocated, so the written count is only stored and read back, never used for messages
               s_next.regs.alloc_count = nw[ALLOC_COUNT_LSB +: 3];
            end
            ADDR_LOW_OFS: begin
               nw = merge({s_reg.regs.addr_low, 2'b00}, PWDATA, PSTRB);
               s_next.regs.addr_low = nw[31:2];
            end
            ADDR_HIGH_OFS: begin
               s_next.regs.addr_high = merge(s_reg.regs.addr_high, PWDATA, PSTRB);
            end
            PAYLOAD_OFS: begin
               nw = merge({16'h0000, s_reg.regs.payload}, PWDATA, PSTRB);
               s_next.regs.payload = nw[15:0];
            end
            default: begin
            end
         endcase
      end

      // Read data registered at the access phase
      if (access && !PWRITE) begin
         case (PADDR)
            CAP_CTRL_OFS: s_next.rdata = cw;
            ADDR_LOW_OFS: s_next.rdata = {s_reg.regs.addr_low, 2'b00};
            ADDR_HIGH_OFS: s_next.rdata = s_reg.regs.addr_high;
            PAYLOAD_OFS: s_next.rdata = {16'h0000, s_reg.regs.payload};
            IRQ_STATUS_OFS: s_next.rdata = {{(32-IRQ_WIDTH){1'b0}}, irq_status};
            IRQ_MASK_OFS: s_next.rdata = {{(32-IRQ_WIDTH){1'b0}}, irq_mask};
            default: s_next.rdata = '0;
         endcase
      end

      // Message generation
      case (s_reg.state)
         ST_IDLE: begin
            if (MSG_REQUEST) begin
               if (s_reg.regs.enable) begin
                  // Snapshot so a later register write cannot tear an issued message
                  s_next.msg.wide = |s_reg.regs.addr_high;
                  s_next.msg.address = s_next.msg.wide ? {s_reg.regs.addr_high, s_reg.regs.addr_low, 2'b00}
                     : {32'h0000_0000, s_reg.regs.addr_low, 2'b00};
                  s_next.msg.data = {16'h0000, s_reg.regs.payload};
                  s_next.msg.to_upstream = 1'b1;
                  s_next.state = ST_ISSUE;
               end else begin
                  s_next.drop_evt = 1'b1;
               end
            end
         end
         ST_ISSUE: begin
            if (MSG_READY) begin
               s_next.state = ST_IDLE;
               s_next.sent_evt = 1'b1;
            end
         end
         default: s_next.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_reg.regs.enable <= 1'b0;
         s_reg.regs.next_ptr <= NEXT_PTR_RESET;
         s_reg.regs.alloc_count <= ALLOC_COUNT_RESET;
         s_reg.regs.addr_low <= ADDR_RESET[31:2];
         s_reg.regs.addr_high <= ADDR_RESET;
         s_reg.regs.payload <= PAYLOAD_RESET;
         s_reg.state <= ST_IDLE;
         s_reg.msg <= '0;
         s_reg.rdata <= '0;
         s_reg.sent_evt <= 1'b0;
         s_reg.drop_evt <= 1'b0;
         s_reg.waited <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   msi_irq_status irq_unit (
      .clk(REF_CLK),
      .rst(RST),
      .event_in({s_reg.drop_evt, s_reg.sent_evt}),
      .status_clr_we(wr && PADDR == IRQ_STATUS_OFS),
      .mask_we(wr && PADDR == IRQ_MASK_OFS),
      .wdata(PWDATA[IRQ_WIDTH-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(IRQ)
   );

   assign PREADY = access & s_reg.waited;
   assign PSLVERR = PREADY & ~mapped;
   assign PRDATA = s_reg.rdata;
   assign MSG_VALID = (s_reg.state == ST_ISSUE);
   assign MSG_WRITE = s_reg.msg;
endmodule // msi_capability_block

// file: verification/msi_cap_checker.sv
/* Port checker for the MSI capability block.
 Assumes one clock domain and a bind on every block instance. */
`timescale 1ns/1ps
module msi_cap_checker
   import msi_cap_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic MSG_VALID,
   input wire logic MSG_READY,
   input wire msg_write_s MSG_WRITE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence s_rd(a);
      PREADY && !PWRITE && PADDR == a;
   endsequence
   sequence s_stall;
      MSG_VALID && !MSG_READY;
   endsequence
   AST_CAP_ID: assert property (s_rd(CAP_CTRL_OFS) |-> PRDATA[7:0] == CAP_ID_VALUE)
      else $error("capability id wrong");
   AST_FIXED: assert property (s_rd(CAP_CTRL_OFS) |-> PRDATA[23] && PRDATA[19:17] == 3'h0)
      else $error("fixed control bits wrong");
   AST_LOW_RSV: assert property (s_rd(ADDR_LOW_OFS) |-> PRDATA[1:0] == 2'h0)
      else $error("address low bits not zero");
   AST_DATA_RSV: assert property (s_rd(PAYLOAD_OFS) |-> PRDATA[31:16] == 16'h0)
      else $error("payload upper half not zero");
   AST_WIDE: assert property (MSG_VALID |-> MSG_WRITE.wide == (MSG_WRITE.address[63:32] != 32'h0))
      else $error("wide flag disagrees with address");
   AST_ALIGN: assert property (MSG_VALID |-> MSG_WRITE.address[1:0] == 2'h0)
      else $error("message address unaligned");
   AST_ROUTE: assert property (MSG_VALID |-> MSG_WRITE.to_upstream)
      else $error("message not routed upstream");
   AST_DATA: assert property (MSG_VALID |-> MSG_WRITE.data[31:16] == 16'h0)
      else $error("message data upper half not zero");
   AST_HOLD: assert property (s_stall |=> MSG_VALID && $stable(MSG_WRITE))
      else $error("message dropped or changed while stalled");
   AST_DONE: assert property (MSG_VALID && MSG_READY |=> !MSG_VALID)
      else $error("message repeated after handshake");
endmodule // msi_cap_checker

bind msi_capability_block msi_cap_checker i_chk (.REF_CLK(REF_CLK), .RST(RST), .PWRITE(PWRITE), .PADDR(PADDR),
   .PRDATA(PRDATA), .PREADY(PREADY), .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY), .MSG_WRITE(MSG_WRITE));

// file: verification/msi_root_model.sv
/* Root side model taking interrupt writes after a programmable stall.
 Assumes the message port shares its clock. */
`timescale 1ns/1ps
module msi_root_model
   import msi_cap_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] stall,
   input wire logic valid,
   input wire msg_write_s wr,
   output logic ready,
   output msg_write_s last,
   output logic [7:0] n_rx
);
   logic [3:0] wait_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready <= 1'b0;
         wait_reg <= 4'h0;
         n_rx <= 8'h00;
         last <= '0;
      end else if (valid && ready) begin
         ready <= 1'b0;
         wait_reg <= 4'h0;
         last <= wr;
         n_rx <= n_rx + 8'h01;
      end else if (valid) begin
         ready <= (wait_reg >= stall);
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule // msi_root_model

// file: verification/msi_capability_block_tb_top.sv
/* Self-checking bench for the MSI capability block.
 Assumes the root model and the bound checker. */
`timescale 1ns/1ps
module msi_capability_block_tb_top;
   import msi_cap_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic psel = 0;
   logic pen = 0;
   logic pwr = 0;
   logic req = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [3:0] stall = 0;
   logic [31:0] prdata;
   logic pready, pslverr, mvalid, mready, irq;
   msg_write_s mwr, last;
   logic [7:0] n_rx;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   msi_capability_block i_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MSG_REQUEST(req),
      .MSG_VALID(mvalid), .MSG_READY(mready), .MSG_WRITE(mwr), .IRQ(irq));
   msi_root_model i_root (.clk(clk), .rst(rst), .stall(stall), .valid(mvalid), .wr(mwr), .ready(mready),
      .last(last), .n_rx(n_rx));
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         test_done();
      end
   end
   // Wide enough for a whole message write, so no address bit is cut off
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Answer taken at the rising edge where PREADY stands; released only after it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1, a, d, q, e);
      // Registered outputs launched by the write edge settle by the next edge
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(0, a, 32'h0, q, e);
      chk({e, q}, {1'b0, exp});
   endtask
   task automatic send(input logic [3:0] s, input logic [7:0] exp);
      int n0;
      n0 = n_rx;
      @(posedge clk);
      stall <= s;
      req <= 1;
      @(posedge clk);
      req <= 0;
      repeat (30) @(posedge clk);
      chk(n_rx, n0 + exp);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      logic e;
      rd(CAP_CTRL_OFS, 32'h0080_0005);
      rd(ADDR_LOW_OFS, 32'h0);
      rd(ADDR_HIGH_OFS, 32'h0);
      rd(PAYLOAD_OFS, 32'h0);
      wr(CAP_CTRL_OFS, 32'hffff_ffff);
      rd(CAP_CTRL_OFS, 32'h00f1_ff05);
      wr(CAP_CTRL_OFS, 32'h0);
      wr(ADDR_LOW_OFS, 32'hffff_ffff);
      rd(ADDR_LOW_OFS, 32'hffff_fffc);
      wr(PAYLOAD_OFS, 32'hffff_ffff);
      rd(PAYLOAD_OFS, 32'h0000_ffff);
      apb(0, 12'h0f0, 32'h0, q, e);
      chk({e, q}, {1'b1, 32'h0});
   endtask
   task automatic t_drop;
      send(0, 0);
      rd(IRQ_STATUS_OFS, 32'h2);
      chk(irq, 0);
      wr(IRQ_MASK_OFS, 32'h3);
      chk(irq, 1);
      wr(IRQ_STATUS_OFS, 32'h2);
      chk(irq, 0);
   endtask
   task automatic t_msg;
      wr(ADDR_LOW_OFS, 32'h0000_1000);
      wr(PAYLOAD_OFS, 32'hffff_1234);
      wr(CAP_CTRL_OFS, 32'h0071_0000);
      send(3, 1);
      chk(last, {64'h1000, 32'h1234, 1'b0, 1'b1});
      chk(irq, 1);
      wr(ADDR_HIGH_OFS, 32'h1);
      send(0, 1);
      chk(last, {64'h1_0000_1000, 32'h1234, 1'b1, 1'b1});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      t_regs();
      t_drop();
      t_msg();
      test_done();
   end
endmodule // msi_capability_block_tb_top
